// >>> cmf_pkg.sv
// Shared constants, types and parity helpers for the memory and fault interface.
package cmf_pkg;

  // Clock and the two derived sequencing rates.
  localparam int CLOCK_MHZ = 125;
  localparam int CORE_CYCLE_NS = 400;
  localparam int MEM_RATE_KHZ = 5000;
  localparam int CORE_CYCLES = (CORE_CYCLE_NS * CLOCK_MHZ) / 1000;
  localparam int MEM_CYCLES = (CLOCK_MHZ * 1000) / MEM_RATE_KHZ;

  // Data path widths.
  localparam int WORD_W = 32;
  localparam int SLICE_W = 11;
  localparam int SLICES = 3;
  localparam int STREAM_W = 12;
  localparam int GROUP_W = 3;
  localparam int ADDR_DROP = 2;
  localparam int RAM_WORDS = 48;
  localparam int CONST_WORDS = 16;
  localparam int CHECK_W = 97;

  // Data register select microfield codes.
  localparam logic [1:0] MDR_SEL_MEMORY = 2'h0;
  localparam logic [1:0] MDR_SEL_PANEL_DATA = 2'h1;
  localparam logic [1:0] MDR_SEL_PANEL_ADDR = 2'h2;
  localparam logic [1:0] MDR_SEL_SWAP = 2'h3;

  // Operand size codes for the part selected from a returned word.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_FULL = 2'h2;

  // Old and new status word byte addresses, one fixed pair per class.
  localparam logic [18:0] STOP_OLD_PSW = 19'h00100;
  localparam logic [18:0] STOP_NEW_PSW = 19'h00108;
  localparam logic [18:0] START_OLD_PSW = 19'h00110;
  localparam logic [18:0] START_NEW_PSW = 19'h00118;
  localparam logic [18:0] INIT_OLD_PSW = 19'h00120;
  localparam logic [18:0] INIT_NEW_PSW = 19'h00128;
  localparam logic [18:0] IO_OLD_PSW = 19'h00038;
  localparam logic [18:0] IO_NEW_PSW = 19'h00078;
  localparam logic [18:0] EXT_OLD_PSW = 19'h00018;
  localparam logic [18:0] EXT_NEW_PSW = 19'h00058;
  localparam logic [18:0] PROG_OLD_PSW = 19'h00028;
  localparam logic [18:0] PROG_NEW_PSW = 19'h00068;

  typedef enum logic [2:0] {
    MEM_IDLE, MEM_ADDR, MEM_WRITE, MEM_SLICE, MEM_DONE
  } cmf_mem_state_type;

  typedef enum logic [2:0] {
    INT_NONE, INT_STOP, INT_START, INT_INIT, INT_IO, INT_EXT, INT_PROG
  } cmf_int_type;

  // Odd parity bit for a data word: set when the word has an even count of ones.
  function automatic logic gen_par(input logic [WORD_W-1:0] w);
    gen_par = ~^w;
  endfunction : gen_par

  // True when a zero-padded word plus its parity bit holds an odd count of ones.
  function automatic logic odd_ok(input logic [CHECK_W-1:0] w);
    odd_ok = ^w;
  endfunction : odd_ok

endpackage : cmf_pkg

// >>> cmf_bus_voter.sv
// Voter and switch over up to three incoming memory bus slices.
`timescale 1ns/1ns
module cmf_bus_voter (
  input wire logic [10:0] busA, // Slice from memory bus 0.
  input wire logic [10:0] busB, // Slice from memory bus 1.
  input wire logic [10:0] busC, // Slice from memory bus 2.
  input wire logic [2:0] useMask, // Buses assigned to this stream.
  output logic [10:0] voted, // Selected, compared or voted slice.
  output logic disagree // Duplex comparison mismatch.
);

  // One bus passes, two are compared, three are voted bit by bit.
  always_comb begin
    voted = 11'h000;
    disagree = 1'b0;
    unique case (useMask)
      3'h1: voted = busA;
      3'h2: voted = busB;
      3'h4: voted = busC;
      3'h3: begin
        voted = busA;
        disagree = busA != busB;
      end
      3'h5: begin
        voted = busA;
        disagree = busA != busC;
      end
      3'h6: begin
        voted = busB;
        disagree = busB != busC;
      end
      // A single bad bus is outvoted silently; that is the point of the third copy.
      3'h7: voted = (busA & busB) | (busA & busC) | (busB & busC);
      3'h0: voted = 11'h000;
    endcase
  end

endmodule : cmf_bus_voter

// >>> cmf_mem_fault_core.sv
// Memory interface, parity, fault and interrupt logic of the processing element.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module cmf_mem_fault_core (
  input wire logic clock, // 125 MHz system clock.
  input wire logic reset, // Asynchronous reset, active high.
  output logic coreTick, // One pulse per microinstruction cycle.
  input wire logic memStart, // Microprogram starts a memory transfer.
  input wire logic memWrite, // Started transfer is a write.
  input wire logic [1:0] opSize, // Operand size of a read.
  input wire logic [31:0] baseReg, // Base register value.
  input wire logic [31:0] indexReg, // Index register value.
  input wire logic [11:0] disp, // Instruction displacement.
  input wire logic [31:0] writeData, // Data for a write transfer.
  output logic memBusy, // Transfer accepted or in progress.
  output logic memDone, // Transfer finished pulse.
  output logic [31:0] operand, // Part selected from the read word.
  output logic [29:0] memAddr, // Word address toward memory.
  output logic memRequest, // Memory cycle in progress.
  output logic memWriteOut, // Memory cycle is a write.
  input wire logic sliceValid, // Memory presents a slice.
  input wire logic [10:0] busA, // Memory bus 0 slice.
  input wire logic [10:0] busB, // Memory bus 1 slice.
  input wire logic [10:0] busC, // Memory bus 2 slice.
  output logic [31:0] procBus, // Processor bus output data.
  output logic procBusParity, // Processor bus parity bit.
  input wire logic [11:0] streamLines, // Stream assignment from controller.
  input wire logic mdrLoad, // Load data register per select.
  input wire logic [1:0] mdrSelect, // Data register select microfield.
  input wire logic [31:0] panelData, // Panel data switches.
  input wire logic [31:0] panelAddr, // Panel address switches.
  output logic [32:0] mdrValue, // Data register with parity on top.
  input wire logic [31:0] aluOut, // ALU output toward the bus.
  input wire logic [31:0] marMux, // Address register mux output.
  input wire logic [31:0] mqrMux, // Quotient register mux output.
  output logic aluParity, // Parity for ALU output.
  output logic marParity, // Parity for address mux.
  output logic mqrParity, // Parity for quotient mux.
  input wire logic [23:0] formatWord, // Format lookup store word.
  input wire logic formatPar, // Its parity bit.
  input wire logic [9:0] microAddr, // Microprogram address register.
  input wire logic microAddrPar, // Its parity bit.
  input wire logic [95:0] microWord, // Microprogram store word.
  input wire logic microWordPar, // Its parity bit.
  input wire logic [5:0] rfAddr, // Register file address.
  input wire logic rfWrite, // Register file write strobe.
  input wire logic rfRead, // Register file read strobe.
  input wire logic [31:0] rfWriteData, // Register file write data.
  output logic [31:0] rfReadData, // Register file read data.
  input wire logic stopIrq, // Controller stop interrupt pin.
  input wire logic startIrq, // Controller start interrupt pin.
  input wire logic initMemIrq, // Controller memory initialize pin.
  input wire logic ioIrq, // I/O processor interrupt pin.
  input wire logic extIrq, // External interrupt pin.
  input wire logic ioEnable, // Status word I/O enable bit.
  input wire logic extEnable, // Status word external enable bit.
  input wire logic [3:0] progMask, // Program mask, one enables.
  input wire logic [3:0] progCause, // Maskable program causes.
  input wire logic progOther, // Unmaskable program cause.
  input wire logic fetchPoint, // Interruptible point of fetch.
  output logic intTaken, // Interrupt taken pulse.
  output cmf_pkg::cmf_int_type intClass, // Class of taken interrupt.
  output logic [18:0] oldPswAddr, // Where to save the old status.
  output logic [18:0] newPswAddr, // Where to load the new status.
  output logic elementFault // Fault line to the controller.
);

  typedef struct packed {
    logic [5:0] coreCnt;
    logic [4:0] memCnt;
    logic coreTick;
    logic memTick;
    logic valid1;
    logic valid2;
    logic [32:0] bus1;
    logic [32:0] bus2;
    logic [11:0] strm1;
    logic [11:0] strm2;
    logic [4:0] irq1;
    logic [4:0] irq2;
    logic [4:0] irqPrev;
    logic [4:0] pend;
    cmf_pkg::cmf_mem_state_type memState;
    logic [1:0] slice;
    logic startPend;
    logic writeOp;
    logic [31:0] wdata;
    logic [1:0] lane;
    logic [1:0] size;
    logic [29:0] addr;
    logic req;
    logic we;
    logic done;
    logic [32:0] mdr;
    logic mdrChk;
    logic [31:0] operand;
    logic [31:0] outData;
    logic outPar;
    logic [31:0] procBus;
    logic procPar;
    logic fault;
    logic aluPar;
    logic marPar;
    logic mqrPar;
    logic [32:0] rfData;
    logic rfChk;
    logic taken;
    cmf_pkg::cmf_int_type intClass;
    logic [18:0] oldPsw;
    logic [18:0] newPsw;
  } cmf_state_type;

  localparam logic [5:0] CORE_LAST = 6'(cmf_pkg::CORE_CYCLES - 1);
  localparam logic [4:0] MEM_LAST = 5'(cmf_pkg::MEM_CYCLES - 1);

  cmf_state_type st_reg;
  cmf_state_type st_next;
  logic [32:0] rfMem [0:cmf_pkg::RAM_WORDS-1];
  logic [32:0] rfWord;
  logic [31:0] effAddr;
  logic [10:0] voted;
  logic disagree;
  logic [2:0] useMask;

  // Big-endian part select; halves are sign-extended as fixed point values.
  function automatic logic [31:0] pick_part(input logic [31:0] w, input logic [1:0] lane,
                                            input logic [1:0] size);
    logic [31:0] sh;
    sh = w << {lane, 3'h0};
    if (size == cmf_pkg::SIZE_BYTE) begin
      pick_part = {24'h000000, sh[31:24]};
    end else if (size == cmf_pkg::SIZE_HALF) begin
      sh = w << {lane[1], 4'h0};
      pick_part = {{16{sh[31]}}, sh[31:16]};
    end else begin
      pick_part = w;
    end
  endfunction : pick_part

  // Constant words of the register file: small integers used by the microprogram.
  function automatic logic [31:0] const_word(input logic [3:0] idx);
    const_word = {28'h0000000, idx};
  endfunction : const_word

  // Each of the low three 3-bit groups of the stream lines names one element; a nonzero group enables its bus.
  assign useMask = {st_reg.strm2[8:6] != 3'h0, st_reg.strm2[5:3] != 3'h0,
                    st_reg.strm2[2:0] != 3'h0};

  // Address arithmetic uses full register widths; software keeps it in range.
  assign effAddr = baseReg + indexReg + {20'h00000, disp};

  cmf_bus_voter voter (
    .busA(st_reg.bus2[32:22]),
    .busB(st_reg.bus2[21:11]),
    .busC(st_reg.bus2[10:0]),
    .useMask(useMask),
    .voted(voted),
    .disagree(disagree)
  );

  // Register file read: RAM words below 48, constant words above.
  always_comb begin
    if (rfAddr < 6'(cmf_pkg::RAM_WORDS)) begin
      rfWord = rfMem[rfAddr];
    end else begin
      rfWord = {cmf_pkg::gen_par(const_word(rfAddr[3:0])), const_word(rfAddr[3:0])};
    end
  end

  // RAM words carry their own parity; writes to the constant area are ignored.
  always_ff @(posedge clock) begin
    if (rfWrite && rfAddr < 6'(cmf_pkg::RAM_WORDS)) begin
      rfMem[rfAddr] <= {cmf_pkg::gen_par(rfWriteData), rfWriteData};
    end
  end

  // Next state of all control and data registers.
  always_comb begin
    logic [4:0] rise;
    logic [4:0] clr;
    logic perr;
    logic restart;
    rise = 5'h00;
    clr = 5'h00;
    perr = 1'b0;
    restart = 1'b0;
    st_next = st_reg;

    // Core and memory-control rates derived from the one clock.
    st_next.coreTick = st_reg.coreCnt == CORE_LAST;
    st_next.coreCnt = st_next.coreTick ? 6'h00 : st_reg.coreCnt + 6'h01;
    st_next.memTick = st_reg.memCnt == MEM_LAST;
    st_next.memCnt = st_next.memTick ? 5'h00 : st_reg.memCnt + 5'h01;

    // Pins from the memories and controller pass two flip-flops first.
    st_next.valid1 = sliceValid;
    st_next.valid2 = st_reg.valid1;
    st_next.bus1 = {busA, busB, busC};
    st_next.bus2 = st_reg.bus1;
    st_next.strm1 = streamLines;
    st_next.strm2 = st_reg.strm1;
    st_next.irq1 = {stopIrq, startIrq, initMemIrq, ioIrq, extIrq};
    st_next.irq2 = st_reg.irq1;
    st_next.irqPrev = st_reg.irq2;
    rise = st_reg.irq2 & ~st_reg.irqPrev;

    st_next.done = 1'b0;
    st_next.mdrChk = 1'b0;
    st_next.taken = 1'b0;

    // A start is held until the next memory-control tick picks it up.
    if (memStart && st_reg.memState == cmf_pkg::MEM_IDLE && !st_reg.startPend) begin
      st_next.startPend = 1'b1;
      st_next.writeOp = memWrite;
      st_next.wdata = writeData;
      st_next.lane = effAddr[1:0];
      st_next.size = opSize;
      st_next.addr = effAddr[31:cmf_pkg::ADDR_DROP];
    end

    // The transfer sequence advances only on memory ticks, free of the core.
    if (st_reg.memTick) begin
      unique case (st_reg.memState)
        cmf_pkg::MEM_IDLE: begin
          if (st_reg.startPend) begin
            st_next.startPend = 1'b0;
            st_next.req = 1'b1;
            st_next.we = st_reg.writeOp;
            st_next.slice = 2'h0;
            st_next.memState = cmf_pkg::MEM_ADDR;
          end
        end
        cmf_pkg::MEM_ADDR: begin
          if (st_reg.writeOp) begin
            st_next.outData = st_reg.wdata;
            st_next.outPar = cmf_pkg::gen_par(st_reg.wdata);
            st_next.memState = cmf_pkg::MEM_WRITE;
          end else begin
            st_next.memState = cmf_pkg::MEM_SLICE;
          end
        end
        cmf_pkg::MEM_WRITE: st_next.memState = cmf_pkg::MEM_DONE;
        cmf_pkg::MEM_SLICE: begin
          if (st_reg.valid2) begin
            // Parity and the top ten data bits arrive first.
            case (st_reg.slice)
              2'h0: st_next.mdr[32:22] = voted;
              2'h1: st_next.mdr[21:11] = voted;
              2'h2: st_next.mdr[10:0] = voted;
              default: st_next.mdr = st_reg.mdr;
            endcase
            perr = disagree;
            st_next.slice = st_reg.slice + 2'h1;
            if (st_reg.slice == 2'(cmf_pkg::SLICES - 1)) begin
              st_next.mdrChk = 1'b1;
              st_next.memState = cmf_pkg::MEM_DONE;
            end
          end
        end
        cmf_pkg::MEM_DONE: begin
          st_next.req = 1'b0;
          st_next.we = 1'b0;
          st_next.done = 1'b1;
          if (!st_reg.writeOp) begin
            st_next.operand = pick_part(st_reg.mdr[31:0], st_reg.lane, st_reg.size);
          end
          st_next.memState = cmf_pkg::MEM_IDLE;
        end
      endcase
    end

    // Data register alternative sources; memory data arrives only via the voter.
    if (mdrLoad) begin
      unique case (mdrSelect)
        cmf_pkg::MDR_SEL_MEMORY: st_next.mdr = st_next.mdr;
        cmf_pkg::MDR_SEL_PANEL_DATA: begin
          st_next.mdr = {cmf_pkg::gen_par(panelData), panelData};
          st_next.mdrChk = 1'b1;
        end
        cmf_pkg::MDR_SEL_PANEL_ADDR: begin
          st_next.mdr = {cmf_pkg::gen_par(panelAddr), panelAddr};
          st_next.mdrChk = 1'b1;
        end
        cmf_pkg::MDR_SEL_SWAP: begin
          st_next.mdr = {st_next.mdr[32], st_next.mdr[15:0], st_next.mdr[31:16]};
          st_next.mdrChk = 1'b1;
        end
      endcase
    end

    // Parity generated for outgoing and multiplexed values.
    st_next.aluPar = cmf_pkg::gen_par(aluOut);
    st_next.marPar = cmf_pkg::gen_par(marMux);
    st_next.mqrPar = cmf_pkg::gen_par(mqrMux);

    // Register file read is registered and checked one cycle later.
    st_next.rfChk = rfRead;
    if (rfRead) begin
      st_next.rfData = rfWord;
    end

    // Parity checks: data register after every load, stores once per microcycle.
    if (st_reg.mdrChk && !cmf_pkg::odd_ok(97'(st_reg.mdr))) begin
      perr = 1'b1;
    end
    if (st_reg.rfChk && !cmf_pkg::odd_ok(97'(st_reg.rfData))) begin
      perr = 1'b1;
    end
    if (st_reg.coreTick) begin
      if (!cmf_pkg::odd_ok(97'({formatPar, formatWord})) ||
          !cmf_pkg::odd_ok(97'({microAddrPar, microAddr})) ||
          !cmf_pkg::odd_ok({microWordPar, microWord})) begin
        perr = 1'b1;
      end
    end

    // Interrupt selection only at the fetch point, in fixed priority.
    // There is deliberately no machine check class; the controller handles recovery.
    if (fetchPoint) begin
      st_next.taken = 1'b1;
      if (st_reg.pend[4]) begin
        clr = 5'h10;
        st_next.intClass = cmf_pkg::INT_STOP;
        st_next.oldPsw = cmf_pkg::STOP_OLD_PSW;
        st_next.newPsw = cmf_pkg::STOP_NEW_PSW;
      end else if (st_reg.pend[3]) begin
        clr = 5'h08;
        restart = 1'b1;
        st_next.intClass = cmf_pkg::INT_START;
        st_next.oldPsw = cmf_pkg::START_OLD_PSW;
        st_next.newPsw = cmf_pkg::START_NEW_PSW;
      end else if (st_reg.pend[2]) begin
        clr = 5'h04;
        st_next.intClass = cmf_pkg::INT_INIT;
        st_next.oldPsw = cmf_pkg::INIT_OLD_PSW;
        st_next.newPsw = cmf_pkg::INIT_NEW_PSW;
      end else if (st_reg.pend[1] && ioEnable) begin
        clr = 5'h02;
        st_next.intClass = cmf_pkg::INT_IO;
        st_next.oldPsw = cmf_pkg::IO_OLD_PSW;
        st_next.newPsw = cmf_pkg::IO_NEW_PSW;
      end else if (st_reg.pend[0] && extEnable) begin
        clr = 5'h01;
        st_next.intClass = cmf_pkg::INT_EXT;
        st_next.oldPsw = cmf_pkg::EXT_OLD_PSW;
        st_next.newPsw = cmf_pkg::EXT_NEW_PSW;
      end else if ((progCause & progMask) != 4'h0 || progOther) begin
        st_next.intClass = cmf_pkg::INT_PROG;
        st_next.oldPsw = cmf_pkg::PROG_OLD_PSW;
        st_next.newPsw = cmf_pkg::PROG_NEW_PSW;
      end else begin
        st_next.taken = 1'b0;
      end
    end
    // A new request in the clearing cycle survives.
    st_next.pend = (st_reg.pend & ~clr) | rise;

    // Fault holds until the restart; a new error in that cycle still wins.
    st_next.fault = (st_reg.fault && !restart) || perr;

    // A faulty element drives all zeros so a healthy duplex partner prevails.
    st_next.procBus = st_next.fault ? 32'h00000000 : st_next.outData;
    st_next.procPar = st_next.fault ? 1'b0 : st_next.outPar;
  end

  // One register stage for the whole state.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state; busy is a handshake term.
  assign coreTick = st_reg.coreTick;
  assign memBusy = st_reg.startPend || st_reg.memState != cmf_pkg::MEM_IDLE;
  assign memDone = st_reg.done;
  assign operand = st_reg.operand;
  assign memAddr = st_reg.addr;
  assign memRequest = st_reg.req;
  assign memWriteOut = st_reg.we;
  assign procBus = st_reg.procBus;
  assign procBusParity = st_reg.procPar;
  assign mdrValue = st_reg.mdr;
  assign aluParity = st_reg.aluPar;
  assign marParity = st_reg.marPar;
  assign mqrParity = st_reg.mqrPar;
  assign rfReadData = st_reg.rfData[31:0];
  assign intTaken = st_reg.taken;
  assign intClass = st_reg.intClass;
  assign oldPswAddr = st_reg.oldPsw;
  assign newPswAddr = st_reg.newPsw;
  assign elementFault = st_reg.fault;

endmodule : cmf_mem_fault_core

// >>> cmf_mem_fault_asserts.sv
// Port-level checks of the memory and fault interface.
`timescale 1ns/1ns
module cmf_mem_fault_asserts (
  input wire logic clock, // System clock.
  input wire logic reset, // Async reset.
  input wire logic coreTick, // Microcycle pulse.
  input wire logic memDone, // Transfer done.
  input wire logic memRequest, // Memory cycle.
  input wire logic [29:0] memAddr, // Word address.
  input wire logic [31:0] procBus, // Bus data.
  input wire logic procBusParity, // Bus parity.
  input wire logic [31:0] aluOut, // ALU output.
  input wire logic aluParity, // ALU parity.
  input wire logic fetchPoint, // Fetch point.
  input wire logic intTaken, // Take pulse.
  input wire cmf_pkg::cmf_int_type intClass, // Taken class.
  input wire logic [18:0] oldPswAddr, // Old status address.
  input wire logic [18:0] newPswAddr, // New status address.
  input wire logic elementFault // Fault line.
);
  // One clock domain, so clocking and disable are shared.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_alu_par; !$past(reset) |-> aluParity == ~^$past(aluOut); endproperty
  a_alu_par: assert property (p_alu_par) else $error("alu parity wrong");
  property p_bus_par; procBus != 32'h0 |-> procBusParity == ~^procBus; endproperty
  a_bus_par: assert property (p_bus_par) else $error("bus parity wrong");
  property p_zero; elementFault |-> procBus == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("bus not zero in fault");
  property p_tick; coreTick |-> ##50 coreTick; endproperty
  a_tick: assert property (p_tick) else $error("microcycle not 50 clocks");
  property p_done; memDone |-> $past(memRequest) && !memRequest ##1 !memDone; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_addr; memRequest && $past(memRequest) |-> $stable(memAddr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_take; intTaken |-> $past(fetchPoint); endproperty
  a_take: assert property (p_take) else $error("take off fetch point");
  property p_psw; intTaken && intClass == cmf_pkg::INT_EXT |->
    oldPswAddr == cmf_pkg::EXT_OLD_PSW && newPswAddr == cmf_pkg::EXT_NEW_PSW; endproperty
  a_psw: assert property (p_psw) else $error("status addresses wrong");
endmodule : cmf_mem_fault_asserts
bind cmf_mem_fault_core cmf_mem_fault_asserts chk (.clock(clock), .reset(reset),
  .coreTick(coreTick), .memDone(memDone), .memRequest(memRequest), .memAddr(memAddr),
  .procBus(procBus), .procBusParity(procBusParity), .aluOut(aluOut), .aluParity(aluParity),
  .fetchPoint(fetchPoint), .intTaken(intTaken), .intClass(intClass),
  .oldPswAddr(oldPswAddr), .newPswAddr(newPswAddr), .elementFault(elementFault));

// >>> cmf_mem_model.sv
// Memory module model returning one word as three slices on all buses.
`timescale 1ns/1ns
module cmf_mem_model (
  input wire logic clock, // System clock.
  input wire logic memRequest, // Memory cycle.
  input wire logic memWriteOut, // Cycle is a write.
  input wire logic [32:0] word, // Word to return, parity on top.
  output logic sliceValid, // Slice present.
  output logic [10:0] busA, // Bus 0.
  output logic [10:0] busB, // Bus 1.
  output logic [10:0] busC // Bus 2.
);
  logic [10:0] s;
  // A 25-clock valid span holds exactly one memory tick, so no slice is taken twice.
  initial begin
    sliceValid = 1'b0;
    s = 11'h7ff;
    forever begin
      @(posedge memRequest);
      repeat (2) @(posedge clock);
      if (!memWriteOut) begin
        repeat (60) @(posedge clock);
        for (int k = 2; k >= 0; k--) begin
          s <= word[k*11 +: 11];
          sliceValid <= 1'b1;
          repeat (25) @(posedge clock);
          s <= ~s; // Released bus shows no stale value.
          sliceValid <= 1'b0;
          repeat (25) @(posedge clock);
        end
      end
    end
  end
  // Same slice on every bus, as healthy redundant memories give.
  assign busA = s;
  assign busB = s;
  assign busC = s;
endmodule : cmf_mem_model

// >>> tb_top.sv
// Self-checking bench of the memory and fault interface.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic clock, reset, coreTick, memStart, memWrite, memBusy, memDone, memRequest, memWriteOut;
  logic sliceValid, procBusParity, mdrLoad, aluParity, marParity, mqrParity, formatPar;
  logic microAddrPar, microWordPar, rfWrite, rfRead, stopIrq, startIrq, initMemIrq, ioIrq;
  logic extIrq, ioEnable, extEnable, progOther, fetchPoint, intTaken, elementFault;
  logic [1:0] opSize, mdrSelect;
  logic [3:0] progMask, progCause;
  logic [5:0] rfAddr;
  logic [9:0] microAddr;
  logic [10:0] busA, busB, busC;
  logic [11:0] disp, streamLines;
  logic [18:0] oldPswAddr, newPswAddr;
  logic [23:0] formatWord;
  logic [29:0] memAddr;
  logic [31:0] baseReg, indexReg, writeData, operand, procBus, panelData, panelAddr;
  logic [31:0] aluOut, marMux, mqrMux, rfWriteData, rfReadData;
  logic [32:0] mdrValue, rdWord;
  logic [95:0] microWord;
  cmf_pkg::cmf_int_type intClass;
  int n_mismatch, n_tests;
  typedef struct packed {logic [31:0] v; logic p;} cmf_row_type;
  cmf_row_type rows [4] = '{'{32'h0, 1'b1}, '{32'hffffffff, 1'b1}, '{32'h1, 1'b0},
    '{32'h7, 1'b0}};
  cmf_mem_fault_core uut (.*);
  cmf_mem_model mem (.clock(clock), .memRequest(memRequest), .memWriteOut(memWriteOut),
    .word(rdWord), .sliceValid(sliceValid), .busA(busA), .busB(busB), .busC(busC));
  // Free-running 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic test_done();
    $display("Tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Start a transfer and wait for its done pulse; direction and address are caught mid-cycle.
  task automatic mem_op(input logic wr, input logic [32:0] w);
    logic [31:0] e;
    logic [30:0] a;
    e = baseReg + indexReg + {20'h0, disp};
    a = 31'h0;
    rdWord = w;
    @(posedge clock);
    memWrite <= wr;
    memStart <= 1'b1;
    @(posedge clock);
    memStart <= 1'b0;
    @(negedge clock);
    `CHK(memBusy, 1'b1)
    for (int t = 0; t < 400 && memDone !== 1'b1; t++) begin
      @(negedge clock);
      if (memRequest === 1'b1) a = {memWriteOut, memAddr};
    end
    `CHK(memDone, 1'b1)
    `CHK(a, {wr, e[31:2]})
  endtask : mem_op
  task automatic mdr(input logic [1:0] s, input logic [31:0] e);
    @(posedge clock);
    mdrLoad <= 1'b1;
    mdrSelect <= s;
    @(posedge clock);
    mdrLoad <= 1'b0;
    @(negedge clock);
    `CHK(mdrValue, {~^e, e})
  endtask : mdr
  task automatic rf(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    rfAddr <= a;
    rfWrite <= w;
    rfRead <= !w;
    rfWriteData <= d;
    @(posedge clock);
    rfWrite <= 1'b0;
    rfRead <= 1'b0;
    @(negedge clock);
  endtask : rf
  task automatic fetch(input cmf_pkg::cmf_int_type c);
    repeat (6) @(posedge clock);
    fetchPoint <= 1'b1;
    @(posedge clock);
    fetchPoint <= 1'b0;
    for (int t = 0; t < 3 && intTaken !== 1'b1; t++) @(negedge clock);
    `CHK(intTaken, 1'b1)
    `CHK(intClass, c)
  endtask : fetch
  // Watchdog against a hang.
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // Main sequence: parity rows, then hand-written cases.
  initial begin
    {memStart, memWrite, opSize, mdrLoad, mdrSelect, aluOut, marMux, mqrMux, formatWord,
      microAddr, microWord, rfAddr, rfWrite, rfRead, rfWriteData, stopIrq, startIrq,
      initMemIrq, ioIrq, extIrq, ioEnable, extEnable, progMask, progCause, progOther,
      fetchPoint, rdWord} = '0;
    {formatPar, microAddrPar, microWordPar, reset} = 4'hf;
    {baseReg, indexReg, disp, writeData} = {32'h1000, 32'h204, 12'h00b, 32'h12345678};
    {panelData, panelAddr, streamLines} = {32'h0f0f1234, 32'h00abcdef, 12'h049};
    opSize = cmf_pkg::SIZE_FULL;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clock);
      aluOut <= rows[i].v;
      marMux <= rows[i].v;
      mqrMux <= rows[i].v;
      @(posedge clock);
      @(negedge clock);
      `CHK({aluParity, marParity, mqrParity}, {3{rows[i].p}})
    end
    mdr(2'h1, 32'h0f0f1234);
    mdr(2'h3, 32'h12340f0f);
    mdr(2'h2, 32'h00abcdef);
    rf(1'b1, 6'd5, 32'hcafe0001);
    rf(1'b0, 6'd5, 32'h0);
    `CHK(rfReadData, 32'hcafe0001)
    rf(1'b1, 6'd50, 32'hffffffff);
    rf(1'b0, 6'd50, 32'h0);
    `CHK(rfReadData, 32'h2)
    mem_op(1'b0, {~^32'h8421f00d, 32'h8421f00d});
    `CHK(operand, 32'h8421f00d)
    `CHK(elementFault, 1'b0)
    mem_op(1'b1, 33'h0);
    `CHK({procBusParity, procBus}, {~^writeData, writeData})
    // Lane 3 half read takes the low half and sign-extends it.
    opSize <= cmf_pkg::SIZE_HALF;
    mem_op(1'b0, {~^32'h8421f00d, 32'h8421f00d});
    `CHK(operand, 32'hfffff00d)
    @(posedge clock);
    ioIrq <= 1'b1;
    extIrq <= 1'b1;
    extEnable <= 1'b1;
    fetch(cmf_pkg::INT_EXT);
    ioEnable <= 1'b1;
    fetch(cmf_pkg::INT_IO);
    `CHK(oldPswAddr, cmf_pkg::IO_OLD_PSW)
    mem_op(1'b0, {^32'h8421f00d, 32'h8421f00d});
    `CHK({elementFault, procBus}, {1'b1, 32'h0})
    @(posedge clock);
    startIrq <= 1'b1;
    fetch(cmf_pkg::INT_START);
    @(negedge clock);
    `CHK(elementFault, 1'b0)
    // A mid-run reset must clear the held busy, fault, class, old status address and data register outputs.
    @(posedge clock);
    reset <= 1'b1;
    @(negedge clock);
    `CHK({memBusy, elementFault, intClass, oldPswAddr, mdrValue}, 57'h0)
    @(posedge clock);
    reset <= 1'b0;
    test_done();
  end
endmodule : tb_top
